// *** rtl/coad_map.vh ***
/*
 * Constants of the character overlay attribute decoder: register offsets,
 * field positions, reset values and map sizes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef COAD_MAP_VH
`define COAD_MAP_VH

// ------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ------------------------------------------------------------
`define COAD_REG_COLS 8'h00
`define COAD_REG_ROWS 8'h04
`define COAD_REG_MODE 8'h08
`define COAD_REG_MAPADDR 8'h0C
`define COAD_REG_MAPDATA 8'h10
`define COAD_REG_STATUS 8'h14

// ------------------------------------------------------------
// mode register bits and reset values
// ------------------------------------------------------------
`define COAD_MODE_WINBG 0
`define COAD_MODE_BLINK 1
`define COAD_MODE_RES2B 2
`define COAD_MODE_RST 3'h0
`define COAD_COLS_RST 6'h00
`define COAD_ROWS_RST 5'h00

// ------------------------------------------------------------
// map geometry
// ------------------------------------------------------------
`define COAD_MAP_WORDS 3594
`define COAD_MAX_COLS 50
`define COAD_MAX_ROWS 20

// ------------------------------------------------------------
// row attribute word fields
// ------------------------------------------------------------
`define COAD_ROW_EXT 2
`define COAD_ROW_TWOCOL 3
`define COAD_ROW_TBL_HI 1
`define COAD_ROW_TBL_LO 0

// ------------------------------------------------------------
// character attribute word fields
// ------------------------------------------------------------
`define COAD_CH_IDX_HI 7
`define COAD_CH_IDX_LO 0
`define COAD_CH_BLINK 8
`define COAD_CH_FG_HI 23
`define COAD_CH_FG_LO 16
`define COAD_CH_BG_HI 15
`define COAD_CH_BG_LO 9
`define COAD_CH_UP_HI 23
`define COAD_CH_UP_LO 20
`define COAD_CH_F3_HI 19
`define COAD_CH_F3_LO 17
`define COAD_CH_F2_HI 15
`define COAD_CH_F2_LO 12
`define COAD_CH_F1_HI 11
`define COAD_CH_F1_LO 9

`endif

// *** rtl/coad_top.v ***
/*
 * Character overlay attribute decoder: on-chip map memory shared by the
 * character map and resident fonts, host load port, per-character
 * attribute fetch and decode, and pixel code to palette index resolution.
 * Assumes the display timing logic, blink timer and background window
 * logic run on CLK_SYS_I and drive the request inputs synchronously.
 */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
// Overview of operation
// - pixels resolve to 256-entry palette, index zero transparent
// - map memory holds 3594 words of 24 bits
// - resident fonts share the same map memory
// - row word first, then one word per character
// - column and row counts set visible extent
// - row bit 2 selects external fonts
// - row bits 1:0 pick external table
// - row bit 3 makes external fonts two-colour
// - attribute bits 7:0 give character index
// - one-bit foreground from bits 23:16
// - one-bit background bits 15:9, bit0 zero
// - attribute bit 8 marks blinking character
// - window mode overrides per-character background
// - two-colour background chosen independently of foreground
// - two-bit upper index bits from 23:20
// - foreground low bits from 19:17, 15:12, 11:9
// - code 00 uses window or foreground 2
// - four external tables plus resident per row
// - up to 50 by 20, live host update
// - codes 11, 10, 01 select foregrounds 3, 2, 1
// - blink off phase shows background for foreground
`timescale 1ns/1ps
`include "coad_map.vh"

module coad_top #(
   parameter MAP_WORDS = `COAD_MAP_WORDS,
   parameter MAX_COLS = `COAD_MAX_COLS,
   parameter MAX_ROWS = `COAD_MAX_ROWS
) (
   input wire CLK_SYS_I,
   input wire NRST_I,
   input wire [7:0] REG_ADDR_I,
   input wire [23:0] REG_WDATA_I,
   input wire REG_WR_I,
   input wire REG_RD_I,
   output reg [23:0] REG_RDATA_O,
   input wire CHAR_REQ_I,
   input wire [5:0] CHAR_COL_I,
   input wire [4:0] CHAR_ROW_I,
   output wire CHAR_RDY_O,
   output reg ATTR_VALID_O,
   output reg EXT_FONT_O,
   output reg [1:0] EXT_TABLE_INDEX_O,
   output reg TWO_COLOUR_O,
   output reg [7:0] CHAR_INDEX_O,
   output reg BLINK_O,
   input wire FONT_REQ_I,
   input wire [11:0] FONT_ADDR_I,
   output wire FONT_RDY_O,
   output reg FONT_VALID_O,
   output reg [23:0] FONT_DATA_O,
   input wire BLINK_OFF_I,
   input wire [7:0] WIN_BG_INDEX_I,
   input wire PIX_VALID_I,
   input wire [1:0] PIX_CODE_I,
   output reg PIX_VALID_O,
   output reg [7:0] PIX_INDEX_O
);

   // ---------------------------------------------------------
   // declarations
   // ---------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h1;
   localparam [2:0] S_ROW = 3'h2;
   localparam [2:0] S_CHAR = 3'h4;

   reg [23:0] map_mem [0:MAP_WORDS-1];
   reg [23:0] mem_rd_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [5:0] cols_q;
   reg [4:0] rows_q;
   reg [2:0] mode_q;
   reg [11:0] host_addr_q;
   reg [11:0] wr_addr_q;
   reg [23:0] wr_data_q;
   reg wr_pend_q;
   reg [5:0] col_q;
   reg [4:0] row_q;
   reg [3:0] row_attr_q;
   reg [7:0] fg3_q;
   reg [7:0] fg2_q;
   reg [7:0] fg1_q;
   reg [7:0] bg_q;
   reg one_bit_q;
   reg font_pend_q;
   reg [11:0] mem_addr;
   reg mem_rd;
   reg mem_wr;
   reg [7:0] fg_sel;
   wire char_take;
   wire font_take;
   wire host_take;
   wire win_mode;
   wire blink_en;
   wire [23:0] cw;
   wire row_ext;
   wire row_two;
   wire char_one_bit;
   wire [5:0] rows_clamp;

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   // word address of a map entry; entry 0 of a row is its attribute word
   function [11:0] map_addr;
      input [4:0] row;
      input [5:0] entry;
      input [5:0] cols;
      reg [12:0] prod;
      begin
         prod = row * ({1'b0, cols} + 7'h01) + entry;
         map_addr = prod[11:0];
      end
   endfunction

   // clamp a size write to the largest displayable extent
   function [5:0] clamp6;
      input [23:0] v;
      input [5:0] lim;
      begin
         if (v > {18'h0, lim}) begin
            clamp6 = lim;
         end else begin
            clamp6 = v[5:0];
         end
      end
   endfunction

   // row count is five bits wide; the clamp keeps it at or below the row limit
   assign rows_clamp = clamp6(REG_WDATA_I, {1'b0, MAX_ROWS[4:0]});
   assign win_mode = mode_q[`COAD_MODE_WINBG];
   assign blink_en = mode_q[`COAD_MODE_BLINK];

   // ---------------------------------------------------------
   // memory port arbitration
   // ---------------------------------------------------------
   // display reads always win; a host word waits in one holding register,
   // so the display never waits on the host; a second word written while one is held replaces it
   assign CHAR_RDY_O = (state_q == S_IDLE) && !FONT_REQ_I;
   assign FONT_RDY_O = (state_q == S_IDLE);
   assign char_take = CHAR_REQ_I && CHAR_RDY_O;
   assign font_take = FONT_REQ_I && FONT_RDY_O;
   assign host_take = wr_pend_q && (state_q != S_ROW) && !char_take && !font_take;

   // one address per cycle on the single port
   always @* begin
      mem_addr = wr_addr_q;
      mem_rd = 1'b0;
      mem_wr = 1'b0;
      if (state_q == S_ROW) begin
         mem_addr = map_addr(row_q, col_q + 6'h01, cols_q);
         mem_rd = 1'b1;
      end else if (font_take) begin
         mem_addr = FONT_ADDR_I;
         mem_rd = 1'b1;
      end else if (char_take) begin
         mem_addr = map_addr(CHAR_ROW_I, 6'h00, cols_q);
         mem_rd = 1'b1;
      end else if (host_take) begin
         mem_wr = 1'b1;
      end
   end

   // map memory shared by character map and resident fonts
   always @(posedge CLK_SYS_I) begin
      if (mem_wr) begin
         map_mem[mem_addr] <= wr_data_q;
      end
   end

   // registered read port
   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mem_rd_q <= 24'h000000;
      end else if (mem_rd) begin
         mem_rd_q <= map_mem[mem_addr];
      end
   end

   // ---------------------------------------------------------
   // host registers
   // ---------------------------------------------------------
   // a new map word while one is still held replaces it; poll status first
   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cols_q <= `COAD_COLS_RST;
         rows_q <= `COAD_ROWS_RST;
         mode_q <= `COAD_MODE_RST;
         host_addr_q <= 12'h000;
         wr_addr_q <= 12'h000;
         wr_data_q <= 24'h000000;
         wr_pend_q <= 1'b0;
      end else begin
         if (host_take) begin
            wr_pend_q <= 1'b0;
         end
         if (REG_WR_I) begin
            case (REG_ADDR_I)
               `COAD_REG_COLS: begin
                  cols_q <= clamp6(REG_WDATA_I, MAX_COLS[5:0]);
               end
               `COAD_REG_ROWS: begin
                  rows_q <= rows_clamp[4:0];
               end
               `COAD_REG_MODE: begin
                  mode_q <= REG_WDATA_I[2:0];
               end
               `COAD_REG_MAPADDR: begin
                  host_addr_q <= REG_WDATA_I[11:0];
               end
               `COAD_REG_MAPDATA: begin
                  // live update allowed; address steps for block loads
                  wr_addr_q <= host_addr_q;
                  wr_data_q <= REG_WDATA_I;
                  wr_pend_q <= 1'b1;
                  host_addr_q <= host_addr_q + 12'h001;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         REG_RDATA_O <= 24'h000000;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            `COAD_REG_COLS: REG_RDATA_O <= {18'h0, cols_q};
            `COAD_REG_ROWS: REG_RDATA_O <= {19'h0, rows_q};
            `COAD_REG_MODE: REG_RDATA_O <= {21'h0, mode_q};
            `COAD_REG_MAPADDR: REG_RDATA_O <= {12'h0, host_addr_q};
            `COAD_REG_STATUS: REG_RDATA_O <= {22'h0, (state_q != S_IDLE), wr_pend_q};
            default: REG_RDATA_O <= 24'h000000;
         endcase
      end else begin
         REG_RDATA_O <= 24'h000000;
      end
   end

   // ---------------------------------------------------------
   // character fetch sequencer
   // ---------------------------------------------------------
   always @* begin
      case (state_q)
         S_IDLE: state_d = char_take ? S_ROW : S_IDLE;
         S_ROW: state_d = S_CHAR;
         S_CHAR: state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_q <= S_IDLE;
         col_q <= 6'h00;
         row_q <= 5'h00;
         row_attr_q <= 4'h0;
      end else begin
         state_q <= state_d;
         if (char_take) begin
            col_q <= CHAR_COL_I;
            row_q <= CHAR_ROW_I;
         end
         if (state_q == S_ROW) begin
            row_attr_q <= mem_rd_q[3:0]; // bits 23:4 ignored
         end
      end
   end

   // ---------------------------------------------------------
   // attribute decode
   // ---------------------------------------------------------
   assign cw = mem_rd_q;
   assign row_ext = row_attr_q[`COAD_ROW_EXT];
   assign row_two = row_attr_q[`COAD_ROW_TWOCOL];
   // external fonts are always two-bit, unless the row asks for two colours
   assign char_one_bit = row_ext ? row_two : !mode_q[`COAD_MODE_RES2B];

   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ATTR_VALID_O <= 1'b0;
         EXT_FONT_O <= 1'b0;
         EXT_TABLE_INDEX_O <= 2'h0;
         TWO_COLOUR_O <= 1'b0;
         CHAR_INDEX_O <= 8'h00;
         BLINK_O <= 1'b0;
         fg3_q <= 8'h00;
         fg2_q <= 8'h00;
         fg1_q <= 8'h00;
         bg_q <= 8'h00;
         one_bit_q <= 1'b1;
      end else begin
         ATTR_VALID_O <= (state_q == S_CHAR);
         if (state_q == S_CHAR) begin
            EXT_FONT_O <= row_ext;
            // table index is meaningful only with external fonts
            EXT_TABLE_INDEX_O <= row_ext ? row_attr_q[1:0] : 2'h0;
            TWO_COLOUR_O <= row_ext && row_two;
            CHAR_INDEX_O <= cw[`COAD_CH_IDX_HI:`COAD_CH_IDX_LO];
            BLINK_O <= cw[`COAD_CH_BLINK];
            one_bit_q <= char_one_bit;
            if (char_one_bit) begin
               fg3_q <= cw[`COAD_CH_FG_HI:`COAD_CH_FG_LO];
               fg2_q <= cw[`COAD_CH_FG_HI:`COAD_CH_FG_LO];
               fg1_q <= cw[`COAD_CH_FG_HI:`COAD_CH_FG_LO];
               // own background bits, independent of foreground
               bg_q <= {cw[`COAD_CH_BG_HI:`COAD_CH_BG_LO], 1'b0};
            end else begin
               fg3_q <= {cw[`COAD_CH_UP_HI:`COAD_CH_UP_LO],
                         cw[`COAD_CH_F3_HI:`COAD_CH_F3_LO], 1'b0};
               fg2_q <= {cw[`COAD_CH_UP_HI:`COAD_CH_UP_LO],
                         cw[`COAD_CH_F2_HI:`COAD_CH_F2_LO]};
               fg1_q <= {cw[`COAD_CH_UP_HI:`COAD_CH_UP_LO],
                         cw[`COAD_CH_F1_HI:`COAD_CH_F1_LO], 1'b0};
               // with no window the background doubles as foreground 2
               bg_q <= {cw[`COAD_CH_UP_HI:`COAD_CH_UP_LO],
                        cw[`COAD_CH_F2_HI:`COAD_CH_F2_LO]};
            end
         end
      end
   end

   // ---------------------------------------------------------
   // font word reads
   // ---------------------------------------------------------
   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         font_pend_q <= 1'b0;
         FONT_VALID_O <= 1'b0;
         FONT_DATA_O <= 24'h000000;
      end else begin
         font_pend_q <= font_take;
         FONT_VALID_O <= font_take;
         if (font_take) begin
            FONT_DATA_O <= map_mem[FONT_ADDR_I];
         end
      end
   end

   // ---------------------------------------------------------
   // pixel resolution
   // ---------------------------------------------------------
   // code to foreground; two-colour rows only carry 00 and 11, so any
   // non-zero code is foreground in one-bit decode
   always @* begin
      case (PIX_CODE_I)
         2'h3: fg_sel = fg3_q;
         2'h2: fg_sel = fg2_q;
         2'h1: fg_sel = fg1_q;
         default: fg_sel = fg1_q;
      endcase
   end

   // index 00 leaves the palette as transparent; the decoder passes it
   // through unchanged so a window colour of 00 stays see-through
   always @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         PIX_VALID_O <= 1'b0;
         PIX_INDEX_O <= 8'h00;
      end else begin
         PIX_VALID_O <= PIX_VALID_I;
         if (PIX_VALID_I) begin
            if (PIX_CODE_I == 2'h0 || (BLINK_O && blink_en && BLINK_OFF_I)) begin
               // background, also shown by blinking foreground in off phase
               PIX_INDEX_O <= win_mode ? WIN_BG_INDEX_I : bg_q;
            end else begin
               PIX_INDEX_O <= fg_sel;
            end
         end
      end
   end

endmodule // coad_top

// *** verification/coad_top_assertions.sv ***
/* Port timing checker for the overlay attribute decoder.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ps
module coad_top_checker (
   input wire CLK_SYS_I,
   input wire NRST_I,
   input wire REG_RD_I,
   input wire [23:0] REG_RDATA_O,
   input wire CHAR_REQ_I,
   input wire CHAR_RDY_O,
   input wire ATTR_VALID_O,
   input wire EXT_FONT_O,
   input wire [1:0] EXT_TABLE_INDEX_O,
   input wire TWO_COLOUR_O,
   input wire [7:0] CHAR_INDEX_O,
   input wire BLINK_O,
   input wire FONT_REQ_I,
   input wire FONT_RDY_O,
   input wire FONT_VALID_O,
   input wire PIX_VALID_I,
   input wire PIX_VALID_O,
   input wire [7:0] PIX_INDEX_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   // a fetch is taken only while ready, so key the fetch checks on it
   wire take_w;
   assign take_w = CHAR_REQ_I && CHAR_RDY_O;
   fetch_lat_a:
      assert property (take_w |=> !ATTR_VALID_O[*2] ##1 ATTR_VALID_O)
      else $error("attribute answer not three cycles after take");
   fetch_busy_a:
      assert property (take_w |=> !CHAR_RDY_O[*2]) else $error("fetch taken while busy");
   attr_hold_a:
      assert property (!ATTR_VALID_O |-> $stable({EXT_FONT_O, EXT_TABLE_INDEX_O,
         TWO_COLOUR_O, CHAR_INDEX_O, BLINK_O})) else $error("attributes moved without valid");
   ext_only_a:
      assert property (ATTR_VALID_O && !EXT_FONT_O |-> EXT_TABLE_INDEX_O == 2'h0 && !TWO_COLOUR_O)
      else $error("table or two-colour set on resident row");
   font_lat_a:
      assert property (FONT_REQ_I && FONT_RDY_O |=> FONT_VALID_O) else $error("font word late");
   port_share_a:
      assert property (FONT_REQ_I |-> !CHAR_RDY_O) else $error("fetch ready during font read");
   pix_lat_a:
      assert property (PIX_VALID_I |=> PIX_VALID_O) else $error("pixel answer missing");
   pix_hold_a:
      assert property (!PIX_VALID_I |=> !PIX_VALID_O && $stable(PIX_INDEX_O))
      else $error("pixel index moved while idle");
   rdata_idle_a:
      assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 24'h000000)
      else $error("read data outside answer cycle");
   // main scenarios reached
   cover property (take_w);
   cover property (ATTR_VALID_O && TWO_COLOUR_O);
   cover property (PIX_VALID_I && BLINK_O);
   cover property (FONT_REQ_I && FONT_RDY_O);
endmodule // coad_top_checker

bind coad_top coad_top_checker chk (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
   .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .CHAR_REQ_I(CHAR_REQ_I),
   .CHAR_RDY_O(CHAR_RDY_O), .ATTR_VALID_O(ATTR_VALID_O), .EXT_FONT_O(EXT_FONT_O),
   .EXT_TABLE_INDEX_O(EXT_TABLE_INDEX_O), .TWO_COLOUR_O(TWO_COLOUR_O),
   .CHAR_INDEX_O(CHAR_INDEX_O), .BLINK_O(BLINK_O), .FONT_REQ_I(FONT_REQ_I),
   .FONT_RDY_O(FONT_RDY_O), .FONT_VALID_O(FONT_VALID_O), .PIX_VALID_I(PIX_VALID_I),
   .PIX_VALID_O(PIX_VALID_O), .PIX_INDEX_O(PIX_INDEX_O));

// *** verification/coad_host_model.sv ***
/* Host processor model: drives the plain register port and loads map words.
   Assumes the decoder answers reads one cycle after the strobe. */
`timescale 1ns/1ps
`include "coad_map.vh"
module coad_host_model (
   input wire clk_i,
   output reg [7:0] reg_addr_o,
   output reg [23:0] reg_wdata_o,
   output reg reg_wr_o,
   output reg reg_rd_o,
   input wire [23:0] reg_rdata_i
);
   initial begin
      reg_addr_o = 8'hFF;
      reg_wdata_o = 24'h000000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // one-cycle strobes; released lines show the inverse so stale values never help
   task wr_reg(input [7:0] a, input [23:0] d);
      begin
         @(posedge clk_i);
         reg_addr_o <= a;
         reg_wdata_o <= d;
         reg_wr_o <= 1'b1;
         @(posedge clk_i);
         reg_wr_o <= 1'b0;
         reg_addr_o <= ~a;
         reg_wdata_o <= ~d;
      end
   endtask
   task rd_reg(input [7:0] a, output [23:0] d);
      begin
         @(posedge clk_i);
         reg_addr_o <= a;
         reg_rd_o <= 1'b1;
         @(posedge clk_i);
         reg_rd_o <= 1'b0;
         reg_addr_o <= ~a;
         #1 d = reg_rdata_i;
      end
   endtask
   // map words go in through the host port, waiting out the pending flag
   task put_word(input [11:0] a, input [23:0] d);
      integer k;
      reg [23:0] s;
      begin
         wr_reg(`COAD_REG_MAPADDR, {12'h000, a});
         wr_reg(`COAD_REG_MAPDATA, d);
         s = 24'h000001;
         for (k = 0; k < 20 && s[0] !== 1'b0; k = k + 1) begin
            rd_reg(`COAD_REG_STATUS, s);
         end
      end
   endtask
endmodule // coad_host_model

// *** verification/test_coad_top.sv ***
/* Self-checking bench of the overlay attribute decoder with a host model.
   Assumes a 100 MHz clock and a map of 5 columns by 3 rows. */
`timescale 1ns/1ps
`include "coad_map.vh"
module test_coad_top;
   reg clk, nrst, char_req, font_req, blink_off, pix_valid;
   reg [5:0] col;
   reg [4:0] row;
   reg [11:0] font_addr;
   reg [7:0] win;
   reg [1:0] code;
   reg [2:0] mode;
   reg [23:0] rv;
   reg [23:0] m [0:4095];
   integer bad_count, samples_checked, seed, r, c, k;
   wire [7:0] ra;
   wire [23:0] rw, rd_data, font_data;
   wire wr, rd, crdy, avalid, ext, two, blk, frdy, fvalid, pvalid;
   wire [1:0] tbl;
   wire [7:0] cidx, pidx;
   coad_top dut (.CLK_SYS_I(clk), .NRST_I(nrst), .REG_ADDR_I(ra), .REG_WDATA_I(rw),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rd_data), .CHAR_REQ_I(char_req),
      .CHAR_COL_I(col), .CHAR_ROW_I(row), .CHAR_RDY_O(crdy), .ATTR_VALID_O(avalid),
      .EXT_FONT_O(ext), .EXT_TABLE_INDEX_O(tbl), .TWO_COLOUR_O(two), .CHAR_INDEX_O(cidx),
      .BLINK_O(blk), .FONT_REQ_I(font_req), .FONT_ADDR_I(font_addr), .FONT_RDY_O(frdy),
      .FONT_VALID_O(fvalid), .FONT_DATA_O(font_data), .BLINK_OFF_I(blink_off),
      .WIN_BG_INDEX_I(win), .PIX_VALID_I(pix_valid), .PIX_CODE_I(code),
      .PIX_VALID_O(pvalid), .PIX_INDEX_O(pidx));
   coad_host_model host (.clk_i(clk), .reg_addr_o(ra), .reg_wdata_o(rw), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_rdata_i(rd_data));
   // -----------------------------------------------------------
   // comparison, verdict and expectations
   // -----------------------------------------------------------
   task check(input [23:0] seen, input [23:0] want);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons=%0d mismatches=%0d", samples_checked, bad_count);
         if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // palette index a pixel should resolve to, from mode and live inputs
   function [7:0] pix_exp(input [23:0] w, input [23:0] rwd, input [1:0] cd);
      reg one;
      reg [7:0] fg, bg;
      begin
         one = rwd[2] ? rwd[3] : !mode[2];
         if (one) begin
            fg = w[23:16];
            bg = {w[15:9], 1'b0};
         end else begin
            fg = (cd == 2'h3) ? {w[23:20], w[19:17], 1'b0} :
               (cd == 2'h2) ? {w[23:20], w[15:12]} : {w[23:20], w[11:9], 1'b0};
            bg = {w[23:20], w[15:12]};
         end
         if (mode[0]) bg = win;
         pix_exp = (cd == 2'h0 || (w[8] && mode[1] && blink_off)) ? bg : fg;
      end
   endfunction
   // fetch one character, compare its decode, then resolve pixel codes
   task fetch(input [4:0] rr, input [5:0] cc);
      integer j;
      reg [23:0] rwd, w;
      begin
         rwd = m[rr * 6];
         w = m[rr * 6 + 1 + cc];
         @(posedge clk);
         char_req <= 1'b1;
         row <= rr;
         col <= cc;
         @(posedge clk);
         char_req <= 1'b0;
         row <= ~rr;
         col <= ~cc;
         #1;
         for (j = 0; j < 6 && avalid !== 1'b1; j = j + 1) begin
            @(posedge clk);
            #1;
         end
         check(avalid, 24'h1);
         check(ext, rwd[2]);
         check(tbl, rwd[2] ? rwd[1:0] : 2'h0);
         check(two, rwd[2] & rwd[3]);
         check(cidx, w[7:0]);
         check(blk, w[8]);
         for (j = 0; j < 4; j = j + 1) begin
            if (!(rwd[2] && rwd[3]) || j == 0 || j == 3) begin
               @(posedge clk);
               pix_valid <= 1'b1;
               code <= j[1:0];
               blink_off <= $random(seed);
               win <= $random(seed);
               @(posedge clk);
               pix_valid <= 1'b0;
               #1 check(pvalid, 24'h1);
               check(pidx, pix_exp(w, rwd, j[1:0]));
            end
         end
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog well beyond the expected run of some fifteen hundred cycles
   initial begin
      #400000;
      bad_count = bad_count + 1;
      wrap_up;
   end
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      seed = 83;
      bad_count = 0;
      samples_checked = 0;
      {nrst, char_req, font_req, blink_off, pix_valid} = 5'h00;
      {col, row, font_addr, win, code, mode} = 36'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      // every place reads zero after reset, unmapped ones too
      for (k = 0; k < 8; k = k + 1) begin
         host.rd_reg(k * 4, rv);
         check(rv, 24'h0);
      end
      host.wr_reg(`COAD_REG_COLS, 24'h00003F);
      host.rd_reg(`COAD_REG_COLS, rv);
      check(rv, 24'h000032);
      // 5 by 3 plus 4 resident font words stays far inside the budget
      host.wr_reg(`COAD_REG_COLS, 24'h000005);
      host.wr_reg(`COAD_REG_ROWS, 24'h000003);
      host.rd_reg(`COAD_REG_ROWS, rv);
      check(rv, 24'h000003);
      for (r = 0; r < 3; r = r + 1) begin
         rv = $random(seed);
         rv[3:2] = (r == 0) ? 2'h0 : (r == 1) ? 2'h1 : 2'h3;
         m[r * 6] = rv;
         for (c = 1; c < 6; c = c + 1) begin
            m[r * 6 + c] = $random(seed);
            if (c == 1) m[r * 6 + c][8] = 1'b1;
         end
         for (c = 0; c < 6; c = c + 1) host.put_word(r * 6 + c, m[r * 6 + c]);
      end
      for (k = 0; k < 4; k = k + 1) begin
         m[3590 + k] = $random(seed);
         host.put_word(3590 + k, m[3590 + k]);
      end
      // resident font words read back through the font port, last word included
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge clk);
         font_req <= 1'b1;
         font_addr <= 3590 + k;
         @(posedge clk);
         font_req <= 1'b0;
         #1 check(fvalid, 24'h1);
         check(font_data, m[3590 + k]);
      end
      for (k = 0; k < 8; k = k + 1) begin
         mode = k;
         host.wr_reg(`COAD_REG_MODE, {21'h0, mode});
         for (r = 0; r < 3; r = r + 1) begin
            for (c = 0; c < 5; c = c + 1) fetch(r, c);
         end
      end
      host.rd_reg(`COAD_REG_MODE, rv);
      check(rv, 24'h000007);
      // live update beside a running fetch of another word
      m[8] = $random(seed);
      fork
         host.put_word(12'h008, m[8]);
         fetch(0, 1);
      join
      fetch(1, 1);
      host.rd_reg(`COAD_REG_STATUS, rv);
      check(rv, 24'h0);
      wrap_up;
   end
endmodule // test_coad_top
